// [design/sysctl_map.svh]
`ifndef SYSCTL_MAP_SVH
`define SYSCTL_MAP_SVH
`define OFS_SYSTEM_CONTROL 8'h00
`define OFS_IRQ_STATUS 8'h04
`define OFS_IRQ_MASK 8'h08
`define BIT_PROT_DIS 21
`define BIT_REDUCED_VIDEO 20
`define BIT_BURST_DN 15
`define BIT_BURST_UP 14
`define BIT_ACTIVITY 13
`define BIT_ONE_RSVD 12
`define BIT_SHIFT 11
`define BIT_UP 10
`define BIT_DOWN 9
`define BIT_INTERROGATE 8
`define BIT_POWER_SAVE 6
`define BIT_ID_LOCK 5
`define IRQ_ACTIVITY 0
`define IRQ_POWER_DONE 1
`define IRQ_INTERROGATE_DONE 2
`define RST_BURST_DN 1'h1
`define RST_BURST_UP 1'h0
`define RST_POWER_SAVE 1'h1
`define RST_ID_LOCK 1'h1
`endif

// [design/sysctl_pkg.sv]
package sysctl_pkg;
  typedef enum logic [1:0] {
    PWR_IDLE,
    PWR_SHIFT,
    PWR_SETTLE
  } pwr_state_t;
  typedef struct packed {
    pwr_state_t pwr;
    logic settle_up;
  } seq_t;
  typedef struct packed {
    logic up;
    logic down;
    logic interrogate;
  } ctx_t;
  typedef struct packed {
    logic prot_dis;
    logic reduced_video;
    logic burst_dn;
    logic burst_up;
    logic power_save;
    logic id_lock;
    logic activity;
  } glob_t;
  typedef struct packed {
    logic aw_ok;
    logic w_ok;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
  } bus_t;
endpackage

// [design/system_control_mid_fields.sv]
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`include "sysctl_map.svh"
module system_control_mid_fields (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic global_reset_n,
  input wire logic wake_enable,
  input wire logic card_access,
  input wire logic power_req,
  input wire logic power_req_up,
  input wire logic power_shift_done,
  input wire logic power_delay_done,
  input wire logic interrogate_start,
  input wire logic interrogate_done,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic supply_protect_disable,
  output logic reduced_video_enable,
  output logic read_burst_down_en,
  output logic read_burst_up_en,
  output logic low_power_mode_en,
  output logic id_write_lock,
  output logic power_shift_in_progress,
  output logic irq
);
  sysctl_pkg::glob_t glob, next_glob;
  sysctl_pkg::ctx_t ctx, next_ctx;
  sysctl_pkg::seq_t seq, next_seq;
  sysctl_pkg::bus_t bus, next_bus;
  logic glob_rst;
  logic ctx_rst;
  logic [31:0] sc_word;

  // Global reset is active low; bus reset clears wake context without wake.
  assign glob_rst = ~global_reset_n;
  assign ctx_rst = ~global_reset_n | (sys_rst & ~wake_enable);

  function automatic logic [31:0] compose(input sysctl_pkg::glob_t g,
      input sysctl_pkg::ctx_t c, input sysctl_pkg::seq_t s);
    logic [31:0] v;
    v = 32'h0;
    v[`BIT_PROT_DIS] = g.prot_dis;
    v[`BIT_REDUCED_VIDEO] = g.reduced_video;
    v[`BIT_BURST_DN] = g.burst_dn;
    v[`BIT_BURST_UP] = g.burst_up;
    v[`BIT_ACTIVITY] = g.activity;
    v[`BIT_ONE_RSVD] = 1'b1;
    v[`BIT_SHIFT] = s.pwr != sysctl_pkg::PWR_IDLE;
    v[`BIT_UP] = c.up;
    v[`BIT_DOWN] = c.down;
    v[`BIT_INTERROGATE] = c.interrogate;
    v[`BIT_POWER_SAVE] = g.power_save;
    v[`BIT_ID_LOCK] = g.id_lock;
    return v;
  endfunction

  assign sc_word = compose(glob, ctx, seq);

  // Power sequencing and interrogation tracking.
  always_comb begin
    next_ctx = ctx;
    next_seq = seq;
    case (seq.pwr)
      sysctl_pkg::PWR_IDLE: begin
        if (power_req) begin
          next_seq.pwr = sysctl_pkg::PWR_SHIFT;
          next_seq.settle_up = power_req_up;
        end
      end
      sysctl_pkg::PWR_SHIFT: begin
        if (power_shift_done) begin
          next_seq.pwr = sysctl_pkg::PWR_SETTLE;
          next_ctx.up = seq.settle_up;
          next_ctx.down = ~seq.settle_up;
        end
      end
      sysctl_pkg::PWR_SETTLE: begin
        if (power_delay_done) begin
          next_seq.pwr = sysctl_pkg::PWR_IDLE;
          next_ctx.up = 1'b0;
          next_ctx.down = 1'b0;
        end
      end
      default: next_seq.pwr = sysctl_pkg::PWR_IDLE;
    endcase
    if (interrogate_start) begin
      next_ctx.interrogate = 1'b1;
    end else if (interrogate_done) begin
      next_ctx.interrogate = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge ctx_rst) begin
    if (ctx_rst) begin
      ctx <= '{1'b0, 1'b0, 1'b0};
    end else begin
      ctx <= next_ctx;
    end
  end

  // The power-shift sequencer state survives an ordinary bus reset.
  always_ff @(posedge clk or posedge glob_rst) begin
    if (glob_rst) begin
      seq <= '{sysctl_pkg::PWR_IDLE, 1'b0};
    end else begin
      seq <= next_seq;
    end
  end

  // Bus slave and writable fields.
  always_comb begin
    logic [2:0] ev;
    ev = 3'h0;
    next_bus = bus;
    next_glob = glob;
    if (s_axi_awvalid && !bus.aw_ok) begin
      next_bus.aw_ok = 1'b1;
      next_bus.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !bus.w_ok) begin
      next_bus.w_ok = 1'b1;
      next_bus.wdata = s_axi_wdata;
      next_bus.wstrb = s_axi_wstrb;
    end
    if (bus.bvalid && s_axi_bready) begin
      next_bus.bvalid = 1'b0;
    end
    if (bus.rvalid && s_axi_rready) begin
      next_bus.rvalid = 1'b0;
    end
    if (bus.aw_ok && bus.w_ok && !bus.bvalid) begin
      next_bus.aw_ok = 1'b0;
      next_bus.w_ok = 1'b0;
      next_bus.bvalid = 1'b1;
      next_bus.bresp = 2'h0;
      case (bus.awaddr)
        `OFS_SYSTEM_CONTROL: begin
          // Only writable fields update; status and reserved bits ignore it.
          if (bus.wstrb[2]) begin
            next_glob.prot_dis = bus.wdata[`BIT_PROT_DIS];
            next_glob.reduced_video = bus.wdata[`BIT_REDUCED_VIDEO];
          end
          if (bus.wstrb[1]) begin
            next_glob.burst_dn = bus.wdata[`BIT_BURST_DN];
            next_glob.burst_up = bus.wdata[`BIT_BURST_UP];
          end
          if (bus.wstrb[0]) begin
            next_glob.power_save = bus.wdata[`BIT_POWER_SAVE];
            next_glob.id_lock = bus.wdata[`BIT_ID_LOCK];
          end
        end
        `OFS_IRQ_STATUS: begin
          if (bus.wstrb[0]) begin
            next_bus.irq_status = bus.irq_status & ~bus.wdata[2:0];
          end
        end
        `OFS_IRQ_MASK: begin
          if (bus.wstrb[0]) begin
            next_bus.irq_mask = bus.wdata[2:0];
          end
        end
        default: next_bus.bresp = 2'h2;
      endcase
    end
    if (s_axi_arvalid && !bus.rvalid) begin
      next_bus.rvalid = 1'b1;
      next_bus.rresp = 2'h0;
      case (s_axi_araddr)
        `OFS_SYSTEM_CONTROL: begin
          next_bus.rdata = sc_word;
          next_glob.activity = 1'b0;
        end
        `OFS_IRQ_STATUS: next_bus.rdata = {29'h0, bus.irq_status};
        `OFS_IRQ_MASK: next_bus.rdata = {29'h0, bus.irq_mask};
        default: begin
          next_bus.rdata = 32'h0;
          next_bus.rresp = 2'h2;
        end
      endcase
    end
    // Set wins over clear for every hardware-set flag.
    if (card_access) begin
      next_glob.activity = 1'b1;
    end
    ev[`IRQ_ACTIVITY] = card_access;
    ev[`IRQ_POWER_DONE] = seq.pwr == sysctl_pkg::PWR_SETTLE
      && power_delay_done;
    ev[`IRQ_INTERROGATE_DONE] = ctx.interrogate && interrogate_done;
    next_bus.irq_status = next_bus.irq_status | ev;
  end

  always_ff @(posedge clk or posedge glob_rst) begin
    if (glob_rst) begin
      glob <= '{1'b0, 1'b0, `RST_BURST_DN, `RST_BURST_UP,
        `RST_POWER_SAVE, `RST_ID_LOCK, 1'b0};
    end else begin
      glob <= next_glob;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus <= '0;
    end else begin
      bus <= next_bus;
    end
  end

  assign s_axi_awready = ~bus.aw_ok;
  assign s_axi_wready = ~bus.w_ok;
  assign s_axi_bvalid = bus.bvalid;
  assign s_axi_bresp = bus.bresp;
  assign s_axi_arready = ~bus.rvalid;
  assign s_axi_rvalid = bus.rvalid;
  assign s_axi_rdata = bus.rdata;
  assign s_axi_rresp = bus.rresp;
  assign supply_protect_disable = glob.prot_dis;
  assign reduced_video_enable = glob.reduced_video;
  assign read_burst_down_en = glob.burst_dn;
  assign read_burst_up_en = glob.burst_up;
  assign low_power_mode_en = glob.power_save;
  assign id_write_lock = glob.id_lock;
  assign power_shift_in_progress = sc_word[`BIT_SHIFT];
  assign irq = |(bus.irq_status & bus.irq_mask);
endmodule

// [bench/sysctl_chk.sv]
module sysctl_chk (
  input logic clk,
  input logic sys_rst,
  input logic global_reset_n,
  input logic power_req,
  input logic power_delay_done,
  input logic power_shift_in_progress,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic [31:0] s_axi_rdata,
  input logic read_burst_down_en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst || !global_reset_n);
  a_rsvd_high: assert property (
    s_axi_rvalid |-> s_axi_rdata[19:16] == 4'h0) else $error("bad 19:16");
  a_rsvd_low: assert property (s_axi_rvalid |-> !s_axi_rdata[7])
    else $error("bad bit 7");
  a_rsvd_one: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
    |=> s_axi_rvalid && s_axi_rdata[12]) else $error("bad bit 12");
  a_shift_start: assert property (
    power_req && !power_shift_in_progress |=> power_shift_in_progress)
    else $error("no shift");
  a_shift_idle: assert property (
    !power_req && !power_shift_in_progress |=> !power_shift_in_progress)
    else $error("stray shift");
  a_shift_hold: assert property (
    power_shift_in_progress && !power_delay_done
    |=> power_shift_in_progress) else $error("shift dropped");
  a_shift_end: assert property (
    power_shift_in_progress && power_delay_done && !power_req
    |=> !power_shift_in_progress) else $error("shift stuck");
  a_glob_keep: assert property (disable iff (!global_reset_n)
    sys_rst |-> $stable(read_burst_down_en)) else $error("field lost");
endmodule
bind system_control_mid_fields sysctl_chk chk_i (.*);

// [bench/system_control_mid_fields_tb.sv]
module system_control_mid_fields_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, sys_rst = 1'h1, global_reset_n = 1'h0;
  logic wake_enable = 1'h0, power_req_up = 1'h0, s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic [5:0] pu = 6'h00;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, g, r;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, supply_protect_disable, reduced_video_enable;
  logic read_burst_down_en, read_burst_up_en, low_power_mode_en;
  logic id_write_lock, power_shift_in_progress, irq, card_access;
  logic power_req, power_shift_done, power_delay_done;
  logic interrogate_start, interrogate_done;
  logic [33:0] q[$], e;
  logic [1:0] qb[$];
  int n_fail = 0, checked = 0, cyc = 0, seed = 32'h5CE9;
  assign {interrogate_done, interrogate_start, power_delay_done,
    power_shift_done, power_req, card_access} = pu;
  system_control_mid_fields uut (.*);
  always #5 clk = ~clk;
  task stop_test;
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [33:0] v, input logic [33:0] w);
    checked++;
    if (v !== w) begin
      n_fail++;
      $display("mismatch %0t %h %h", $time, v, w);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      stop_test;
    end
  end
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = q.pop_front();
      chk({s_axi_rresp, s_axi_rdata}, e);
    end
    if (s_axi_bvalid && s_axi_bready) begin
      chk(s_axi_bresp, qb.pop_front());
    end
  end
  function automatic logic [33:0] x(input logic [31:0] s);
    return {2'h0, g | 32'h1000 | s};
  endfunction
  task wr(input logic [7:0] a, input logic [31:0] d);
    qb.push_back(a == 8'h0C ? 2'h2 : 2'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
  endtask
  task rd(input logic [7:0] a, input logic [33:0] v);
    q.push_back(v);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (!s_axi_rvalid);
  endtask
  task pulse(input int i);
    pu[i] <= 1'h1;
    @(posedge clk);
    pu[i] <= 1'h0;
    @(posedge clk);
  endtask
  task rst_pulse;
    sys_rst <= 1'h1;
    @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    global_reset_n <= 1'h1;
    @(posedge clk);
    g = 32'h8060;
    rd(8'h00, x(32'h0));
    for (int i = 0; i < 3; i++) begin
      r = i ? $random(seed) : 32'hFFFFFFFF;
      wr(8'h00, r);
      g = r & 32'h30C060;
      chk({read_burst_down_en, read_burst_up_en, low_power_mode_en,
        id_write_lock, supply_protect_disable, reduced_video_enable},
        {g[15:14], g[6:5], g[21:20]});
      rd(8'h00, x(32'h0));
    end
    pulse(0);
    rd(8'h00, x(32'h2000));
    rd(8'h00, x(32'h0));
    rd(8'h04, 34'h1);
    chk(irq, 1'h0);
    wr(8'h08, 32'h1);
    chk(irq, 1'h1);
    wr(8'h04, 32'h1);
    chk(irq, 1'h0);
    for (int i = 0; i < 2; i++) begin
      power_req_up <= !i[0];
      pulse(1);
      chk(power_shift_in_progress, 1'h1);
      rd(8'h00, x(32'h800));
      pulse(2);
      rd(8'h00, x(i ? 32'hA00 : 32'hC00));
      pulse(3);
      chk(power_shift_in_progress, 1'h0);
      rd(8'h00, x(32'h0));
    end
    pulse(4);
    rd(8'h00, x(32'h100));
    pulse(0);
    pulse(1);
    wake_enable <= 1'h1;
    rst_pulse;
    rd(8'h00, x(32'h2900));
    wake_enable <= 1'h0;
    rst_pulse;
    rd(8'h00, x(32'h800));
    pulse(2);
    pulse(3);
    rd(8'h00, x(32'h0));
    pulse(4);
    pulse(5);
    rd(8'h00, x(32'h0));
    wr(8'h0C, 32'hFFFFFFFF);
    rd(8'h00, x(32'h0));
    rd(8'h0C, 34'h200000000);
    global_reset_n <= 1'h0;
    @(posedge clk);
    global_reset_n <= 1'h1;
    @(posedge clk);
    g = 32'h8060;
    rd(8'h00, x(32'h0));
    stop_test;
  end
endmodule
